// *** hw/tmmu_pkg.sv ***
// package of constants for the timer modulator mode unit
// assumes a single 100 MHz core clock domain
package tmmu_pkg;
   // ---------------------------------------------------------------
   // mode field encodings
   // ---------------------------------------------------------------
   localparam logic [3:0] MODE_TIMER    = 4'h0;
   localparam logic [3:0] MODE_TOG_A    = 4'h1;
   localparam logic [3:0] MODE_TOG_B    = 4'h2;
   localparam logic [3:0] MODE_PWM_A    = 4'h3;
   localparam logic [3:0] MODE_PWM_B    = 4'h4;
   localparam logic [3:0] MODE_MOD_A    = 4'h5;
   localparam logic [3:0] MODE_MOD_B    = 4'h6;
   localparam logic [3:0] MODE_TX_A     = 4'h7;
   localparam logic [3:0] MODE_TX_B     = 4'h8;
   localparam logic [3:0] MODE_SPI      = 4'h9;
   localparam logic [3:0] MODE_CAP_B    = 4'hA;
   localparam logic [3:0] MODE_CAP_A    = 4'hB;
   localparam logic [3:0] MODE_SENSOR   = 4'hC;
   // ---------------------------------------------------------------
   // fixed top values
   // ---------------------------------------------------------------
   localparam logic [9:0] TOP_FIX_1     = 10'h0FF;
   localparam logic [9:0] TOP_FIX_2     = 10'h1FF;
   localparam logic [9:0] TOP_FIX_3     = 10'h3FF;
   // ---------------------------------------------------------------
   // edge select and code select encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] EDGE_OFF      = 2'h0;
   localparam logic [1:0] EDGE_RISE     = 2'h1;
   localparam logic [1:0] EDGE_FALL     = 2'h2;
   localparam logic [1:0] EDGE_BOTH     = 2'h3;
   localparam logic [1:0] CODE_NRZ      = 2'h0;
   localparam logic [1:0] CODE_MANCH    = 2'h1;
   localparam logic [1:0] CODE_BIPHASE  = 2'h2;
   localparam logic [1:0] CODE_PWM      = 2'h3;
   // clock source select
   localparam logic [2:0] CLK_SRC_CORE  = 3'h0;
   localparam int         PWM_SUBSLOTS  = 3;
   localparam int         BYTE_BITS     = 8;
   localparam int         RESET_VAL     = 0;
endpackage : tmmu_pkg

// *** hw/tmmu_sync2.sv ***
// two flip-flop synchroniser for one bit
// assumes the input is asynchronous to clk
`timescale 1ns/100ps
module tmmu_sync2 (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic d,
   output logic      q
);
   logic meta_ff;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= 1'b0;
         q       <= 1'b0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule : tmmu_sync2

// *** hw/tmmu_top.sv ***
// timer modulator mode unit: counter, toggle/pwm stage, serial shifter, pin mux
// assumes config ports are static from the core domain; ext pins are async
`timescale 1ns/100ps
module tmmu_top #(
   parameter int CNT_W = 10
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [3:0]       timer_mode,
   input  wire logic             timer_enable_bit,
   input  wire logic [1:0]       fixed_top_select,
   input  wire logic [CNT_W-1:0] compare_value,
   input  wire logic             toggle_preset,
   input  wire logic [2:0]       clock_select,
   input  wire logic             ext_clk_a,
   input  wire logic             ext_clk_b,
   input  wire logic             capacitive_meas_clock,
   input  wire logic             ssi_enable,
   input  wire logic             shift_clock_idle_level,
   input  wire logic [1:0]       code_select,
   input  wire logic [7:0]       tx_data_reg,
   input  wire logic             tx_start,
   input  wire logic             capture_source_select,
   input  wire logic             capture_pin,
   input  wire logic             capture_alt,
   input  wire logic [1:0]       capture_edge_select,
   input  wire logic             meas_start_bit,
   input  wire logic             port_pin_five,
   input  wire logic             port_pin_six,
   input  wire logic             port_pin_seven_oe,
   input  wire logic             port_pin_five_oe,
   input  wire logic             port_pin_six_oe,
   input  wire logic             serial_input_pin,
   output logic                  mod_out_pin_a,
   output logic                  mod_out_pin_a_oe,
   output logic                  mod_out_pin_b,
   output logic                  mod_out_pin_b_oe,
   output logic                  serial_input_oe,
   output logic [7:0]            rx_data,
   output logic                  ssi_busy,
   output logic [CNT_W-1:0]      count_value,
   output logic [CNT_W-1:0]      capture_value,
   output logic                  capture_event,
   output logic                  compare_match,
   output logic                  timer3_capture,
   output logic                  meas_running,
   output logic                  timer_output_clock
);
   // ---------------------------------------------------------------
   // synchronisers for every pin or foreign-clock input
   // ---------------------------------------------------------------
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] syn_in;
   assign raw_in = {serial_input_pin, capture_alt, capture_pin,
                    capacitive_meas_clock, ext_clk_b, ext_clk_a};
   for (genvar gi = 0; gi < NSYNC; gi++) begin : g_sync
      tmmu_sync2 u_sync (
         .clk  (clk),
         .rstn (rstn),
         .d    (raw_in[gi]),
         .q    (syn_in[gi])
      );
   end
   wire s_ext_a  = syn_in[0];
   wire s_ext_b  = syn_in[1];
   wire s_sense  = syn_in[2];
   wire s_cpin   = syn_in[3];
   wire s_calt   = syn_in[4];
   wire s_sin    = syn_in[5];

   // ---------------------------------------------------------------
   // edge history of synchronised inputs
   // ---------------------------------------------------------------
   logic ext_a_d_ff, ext_b_d_ff, sense_d_ff, cap_d_ff;
   wire  cap_src   = capture_source_select ? s_calt : s_cpin;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ext_a_d_ff <= 1'b0;
         ext_b_d_ff <= 1'b0;
         sense_d_ff <= 1'b0;
         cap_d_ff   <= 1'b0;
      end else begin
         ext_a_d_ff <= s_ext_a;
         ext_b_d_ff <= s_ext_b;
         sense_d_ff <= s_sense;
         cap_d_ff   <= cap_src;
      end
   end

   // ---------------------------------------------------------------
   // counter clock select
   // ---------------------------------------------------------------
   wire  is_sensor = (timer_mode == tmmu_pkg::MODE_SENSOR);
   wire  tick_ext_a = s_ext_a & ~ext_a_d_ff;
   wire  tick_ext_b = s_ext_b & ~ext_b_d_ff;
   wire  tick_sense = s_sense & ~sense_d_ff;
   // sensor mode forces the sensor signal as count clock
   wire  cnt_tick = is_sensor ? tick_sense :
                    (clock_select == tmmu_pkg::CLK_SRC_CORE) ? 1'b1 :
                    (clock_select[0] ? tick_ext_a :
                     clock_select[1] ? tick_ext_b : tick_sense);

   // ---------------------------------------------------------------
   // measurement start: armed by start bit, released on a count tick
   // so timer3 and this counter start on the same clock event
   // ---------------------------------------------------------------
   logic meas_arm_ff, meas_run_ff;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meas_arm_ff <= 1'b0;
         meas_run_ff <= 1'b0;
      end else begin
         meas_arm_ff <= is_sensor & meas_start_bit & ~meas_run_ff;
         if (!is_sensor || !meas_start_bit) begin
            meas_run_ff <= 1'b0;
         end else if (meas_arm_ff && cnt_tick) begin
            meas_run_ff <= 1'b1;
         end
      end
   end
   wire  cnt_run = timer_enable_bit & (~is_sensor | meas_run_ff);

   // ---------------------------------------------------------------
   // counter with fixed or programmed top
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] fix_top;
   logic             en_d_ff;
   always_comb begin
      case (fixed_top_select)
         2'h1:    fix_top = CNT_W'(tmmu_pkg::TOP_FIX_1);
         2'h2:    fix_top = CNT_W'(tmmu_pkg::TOP_FIX_2);
         2'h3:    fix_top = CNT_W'(tmmu_pkg::TOP_FIX_3);
         default: fix_top = compare_value;
      endcase
   end
   wire is_pwm   = (timer_mode == tmmu_pkg::MODE_PWM_A) || (timer_mode == tmmu_pkg::MODE_PWM_B);
   // pwm with a fixed top uses compare as duty; otherwise compare ends period
   wire [CNT_W-1:0] top_val = is_pwm ? fix_top : compare_value;
   wire cmp_hit  = cnt_run & cnt_tick & (cnt_ff == compare_value);
   wire top_hit  = cnt_run & cnt_tick & (cnt_ff == top_val);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= '0;
      end else if (!cnt_run) begin
         cnt_ff <= '0;
      end else if (top_hit) begin
         cnt_ff <= '0;
      end else if (cnt_tick) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // toggle flip-flop (m2 stage)
   // ---------------------------------------------------------------
   logic tog_ff;
   wire  en_rise   = timer_enable_bit & ~en_d_ff;
   wire  pwm_fix   = is_pwm & (fixed_top_select != 2'h0);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tog_ff  <= 1'b0;
         en_d_ff <= 1'b0;
      end else begin
         en_d_ff <= timer_enable_bit;
         if (!timer_enable_bit) begin
            tog_ff <= toggle_preset;            // preset only while stopped
         end else if (en_rise && timer_mode == tmmu_pkg::MODE_PWM_B) begin
            tog_ff <= ~tog_ff;
         end else if (pwm_fix && (cmp_hit || top_hit)) begin
            tog_ff <= ~tog_ff;
         end else if (!pwm_fix && (cmp_hit || top_hit && is_pwm)) begin
            tog_ff <= ~tog_ff;
         end
      end
   end

   // ---------------------------------------------------------------
   // timer output clock and serial shift clock derivation
   // ---------------------------------------------------------------
   logic tclk_ff;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tclk_ff <= 1'b0;
      end else if (!cnt_run) begin
         tclk_ff <= 1'b0;
      end else if (top_hit) begin
         tclk_ff <= ~tclk_ff;
      end
   end
   wire half_tick = top_hit;   // one half of the shift clock per top match

   // ---------------------------------------------------------------
   // serial shift unit: modulator coding and master shifting
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {TMMU_IDLE, TMMU_SHIFT} tmmu_ssi_t;
   tmmu_ssi_t   st_ff;
   logic [7:0]  sr_ff;
   logic [7:0]  rx_ff;
   logic [2:0]  bit_ff;
   logic [1:0]  ph_ff;       // sub-slot inside a bit
   logic        sclk_ff;
   logic        bp_lvl_ff;   // bi-phase running level
   wire is_mod = (timer_mode == tmmu_pkg::MODE_MOD_A) || (timer_mode == tmmu_pkg::MODE_MOD_B);
   wire is_ser = (timer_mode == tmmu_pkg::MODE_TX_A) || (timer_mode == tmmu_pkg::MODE_TX_B) ||
                 (timer_mode == tmmu_pkg::MODE_SPI);
   wire is_spi = (timer_mode == tmmu_pkg::MODE_SPI);
   // pwm code uses three sub-slots per bit, the others use two
   wire [1:0] last_ph = (is_mod && code_select == tmmu_pkg::CODE_PWM) ? 2'h2 : 2'h1;
   wire bit_end = half_tick & (ph_ff == last_ph);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff     <= TMMU_IDLE;
         sr_ff     <= 8'h00;
         rx_ff     <= 8'h00;
         bit_ff    <= 3'h0;
         ph_ff     <= 2'h0;
         sclk_ff   <= 1'b0;
         bp_lvl_ff <= 1'b0;
      end else begin
         case (st_ff)
            TMMU_IDLE: begin
               sclk_ff <= shift_clock_idle_level;
               ph_ff   <= 2'h0;
               bit_ff  <= 3'h0;
               if (ssi_enable && tx_start && (is_mod || is_ser)) begin
                  sr_ff <= tx_data_reg;
                  st_ff <= TMMU_SHIFT;
               end
            end
            TMMU_SHIFT: begin
               if (!ssi_enable || !(is_mod || is_ser)) begin
                  st_ff <= TMMU_IDLE;
               end else if (half_tick) begin
                  ph_ff   <= bit_end ? 2'h0 : ph_ff + 2'h1;
                  sclk_ff <= ~sclk_ff;
                  // leading edge samples the slave, trailing edge shifts
                  if (is_spi && ph_ff == 2'h0) begin
                     rx_ff <= {rx_ff[6:0], s_sin};
                  end
                  if (bit_end) begin
                     bp_lvl_ff <= ~bp_lvl_ff;
                     sr_ff     <= {sr_ff[6:0], 1'b0};
                     bit_ff    <= bit_ff + 3'h1;
                     if (bit_ff == 3'(tmmu_pkg::BYTE_BITS - 1)) begin
                        st_ff <= TMMU_IDLE;
                     end
                  end
               end
            end
            default: st_ff <= TMMU_IDLE;
         endcase
      end
   end
   wire shifting = (st_ff == TMMU_SHIFT);
   wire sdo      = sr_ff[7];

   // ---------------------------------------------------------------
   // line coding of the serial data for modulator modes
   // ---------------------------------------------------------------
   logic coded;
   always_comb begin
      case (code_select)
         tmmu_pkg::CODE_MANCH:   coded = (ph_ff == 2'h0) ? ~sdo : sdo;
         tmmu_pkg::CODE_BIPHASE: coded = (ph_ff == 2'h0) ? bp_lvl_ff : (bp_lvl_ff ^ sdo);
         tmmu_pkg::CODE_PWM:     coded = (ph_ff == 2'h0) | ((ph_ff == 2'h1) & sdo);
         default:                coded = sdo;
      endcase
   end
   wire mod_sig = shifting ? coded : 1'b0;

   // ---------------------------------------------------------------
   // capture source edge detection and capture match
   // ---------------------------------------------------------------
   wire is_cap  = (timer_mode == tmmu_pkg::MODE_CAP_A) || (timer_mode == tmmu_pkg::MODE_CAP_B);
   wire c_rise  = cap_src & ~cap_d_ff;
   wire c_fall  = ~cap_src & cap_d_ff;
   wire cap_hit = is_cap & (
                  (capture_edge_select == tmmu_pkg::EDGE_RISE && c_rise) ||
                  (capture_edge_select == tmmu_pkg::EDGE_FALL && c_fall) ||
                  (capture_edge_select == tmmu_pkg::EDGE_BOTH && (c_rise || c_fall)));

   // ---------------------------------------------------------------
   // pin mux: unclaimed pins pass the port values through
   // ---------------------------------------------------------------
   logic a_val, a_own, b_val, b_own;
   always_comb begin
      a_val = port_pin_five;
      a_own = 1'b0;
      b_val = port_pin_six;
      b_own = 1'b0;
      case (timer_mode)
         tmmu_pkg::MODE_TOG_A, tmmu_pkg::MODE_PWM_A, tmmu_pkg::MODE_CAP_A: begin
            a_val = tog_ff;
            a_own = 1'b1;
         end
         tmmu_pkg::MODE_TOG_B, tmmu_pkg::MODE_PWM_B, tmmu_pkg::MODE_CAP_B: begin
            b_val = tog_ff;
            b_own = 1'b1;
         end
         tmmu_pkg::MODE_MOD_A: begin
            a_val = mod_sig;
            a_own = 1'b1;
         end
         tmmu_pkg::MODE_MOD_B: begin
            b_val = mod_sig;
            b_own = 1'b1;
         end
         tmmu_pkg::MODE_TX_A, tmmu_pkg::MODE_SPI: begin
            a_val = sdo;
            a_own = 1'b1;
            b_val = sclk_ff;
            b_own = 1'b1;
         end
         tmmu_pkg::MODE_TX_B: begin
            a_val = sclk_ff;
            a_own = 1'b1;
            b_val = sdo;
            b_own = 1'b1;
         end
         default: begin
            a_own = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // registered outputs: one flop stage keeps mode changes glitch free
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mod_out_pin_a      <= 1'b0;
         mod_out_pin_a_oe   <= 1'b0;
         mod_out_pin_b      <= 1'b0;
         mod_out_pin_b_oe   <= 1'b0;
         serial_input_oe    <= 1'b0;
         rx_data            <= 8'h00;
         ssi_busy           <= 1'b0;
         count_value        <= '0;
         capture_value      <= '0;
         capture_event      <= 1'b0;
         compare_match      <= 1'b0;
         timer3_capture     <= 1'b0;
         meas_running       <= 1'b0;
         timer_output_clock <= 1'b0;
      end else begin
         mod_out_pin_a      <= a_val;
         mod_out_pin_a_oe   <= a_own ? 1'b1 : port_pin_five_oe;
         mod_out_pin_b      <= b_val;
         mod_out_pin_b_oe   <= b_own ? 1'b1 : port_pin_six_oe;
         // the third pin is input in spi mode, port-owned otherwise
         serial_input_oe    <= is_spi ? 1'b0 : port_pin_seven_oe;
         rx_data            <= rx_ff;
         ssi_busy           <= shifting;
         count_value        <= cnt_ff;
         if (cap_hit) begin
            capture_value   <= cnt_ff;
         end
         capture_event      <= cap_hit;
         compare_match      <= cmp_hit;
         timer3_capture     <= is_sensor & meas_run_ff & cmp_hit;
         meas_running       <= meas_run_ff;
         timer_output_clock <= tclk_ff;
      end
   end
endmodule : tmmu_top

// *** dv/tmmu_asserts.sv ***
// checker of pin routing, shift clock idle level and capture gating at the unit's ports
// assumes one clk domain; registered outputs lag their cause by one clk
`timescale 1ns/100ps
module tmmu_asserts (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic [3:0] timer_mode,
   input wire logic       port_pin_five,
   input wire logic       port_pin_six,
   input wire logic       shift_clock_idle_level,
   input wire logic [1:0] capture_edge_select,
   input wire logic       mod_out_pin_a,
   input wire logic       mod_out_pin_a_oe,
   input wire logic       mod_out_pin_b,
   input wire logic       serial_input_oe,
   input wire logic       ssi_busy,
   input wire logic       capture_event,
   input wire logic       meas_running
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   AST_TIMER_PORT: assert property ((timer_mode == tmmu_pkg::MODE_TIMER)[*2] |->
      mod_out_pin_a == $past(port_pin_five) && mod_out_pin_b == $past(port_pin_six)) else $error("pins not port");
   AST_TOG_A_FREE_B: assert property ((timer_mode == tmmu_pkg::MODE_TOG_A)[*2] |->
      mod_out_pin_b == $past(port_pin_six)) else $error("pin b not port in toggle a");
   AST_TOG_B_FREE_A: assert property ((timer_mode == tmmu_pkg::MODE_TOG_B)[*2] |->
      mod_out_pin_a == $past(port_pin_five)) else $error("pin a not port in toggle b");
   AST_PWM_A_DRIVE: assert property ((timer_mode == tmmu_pkg::MODE_PWM_A)[*2] |-> mod_out_pin_a_oe)
      else $error("pwm pin a not driven");
   AST_SPI_INPUT: assert property ((timer_mode == tmmu_pkg::MODE_SPI)[*2] |-> !serial_input_oe)
      else $error("serial input driven in spi");
   AST_SCLK_IDLE: assert property ((timer_mode == tmmu_pkg::MODE_TX_A && !ssi_busy
      && $stable(shift_clock_idle_level))[*3] |-> mod_out_pin_b == shift_clock_idle_level) else $error("sclk idle");
   AST_FRAME_LEN: assert property ($rose(ssi_busy) |-> ssi_busy[*8])
      else $error("frame too short");
   AST_EDGE_OFF: assert property ((capture_edge_select == tmmu_pkg::EDGE_OFF)[*6] |-> !capture_event)
      else $error("capture with edges off");
   cover property ($rose(ssi_busy));
   cover property (capture_event);
   cover property ($rose(meas_running));
endmodule : tmmu_asserts

bind tmmu_top tmmu_asserts u_asserts (.clk, .rstn, .timer_mode, .port_pin_five, .port_pin_six,
   .shift_clock_idle_level, .capture_edge_select, .mod_out_pin_a, .mod_out_pin_a_oe, .mod_out_pin_b,
   .serial_input_oe, .ssi_busy, .capture_event, .meas_running);

// *** dv/tmmu_periph.sv ***
// serial peripheral model: takes master data on leading clock edges, returns its own byte
// assumes en is high for one whole frame; its line pattern changes once its byte is spent
`timescale 1ns/100ps
module tmmu_periph (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       en,
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic [7:0] tx_byte,
   output logic            miso,
   output logic [7:0]      rx_byte
);
   logic       sclk_d;
   logic [3:0] edge_n;
   logic [7:0] sh;
   assign miso = sh[7];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {sclk_d, edge_n, sh, rx_byte} <= '0;
      end else begin
         sclk_d <= sclk;
         if (!en) begin
            edge_n <= '0;
            sh     <= tx_byte; // msb waits on the line before the first edge
         end else if (sclk != sclk_d) begin
            edge_n <= edge_n + 4'h1;
            if (!edge_n[0]) rx_byte <= {rx_byte[6:0], mosi};
            else sh <= {sh[6:0], ~sh[7]};
         end
      end
   end
endmodule : tmmu_periph

// *** dv/tb.sv ***
// self-checking bench: pin routing, fixed tops, link clock count, serial frames, capture edges
// assumes tmmu_top with CNT_W 10, a 100 MHz clk and the peripheral model on the serial pins
`timescale 1ns/100ps
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin err_total++; $display("[FAIL] %0t %s", $time, m); end end
module tb;
   logic       clk, rstn, timer_enable_bit, toggle_preset, ext_clk_a, ext_clk_b, ssi_enable, shift_clock_idle_level;
   logic       tx_start, capture_source_select, capture_pin, capture_alt, meas_start_bit, port_pin_five, port_pin_six;
   logic       port_pin_seven_oe, port_pin_five_oe, port_pin_six_oe, mod_out_pin_a, mod_out_pin_a_oe, mod_out_pin_b;
   logic       mod_out_pin_b_oe, serial_input_oe, ssi_busy, capture_event, meas_running, miso, timer3_capture;
   logic [1:0] fixed_top_select, code_select, capture_edge_select;
   logic [2:0] clock_select;
   logic [3:0] timer_mode;
   logic [7:0] tx_data_reg, rx_data, slave_byte, slave_rx, b;
   logic [9:0] compare_value, count_value, c0, mx;
   logic [9:0] tops [4] = '{10'h05A, 10'h0FF, 10'h1FF, 10'h3FF};
   int         err_total, compares, seed, ev_n;
   tmmu_top #(.CNT_W(10)) dut (.clk, .rstn, .timer_mode, .timer_enable_bit, .fixed_top_select, .compare_value,
      .toggle_preset, .clock_select, .ext_clk_a, .ext_clk_b, .capacitive_meas_clock(ext_clk_a), .ssi_enable,
      .shift_clock_idle_level, .code_select, .tx_data_reg, .tx_start, .capture_source_select, .capture_pin,
      .capture_alt, .capture_edge_select, .meas_start_bit, .port_pin_five, .port_pin_six, .port_pin_seven_oe,
      .port_pin_five_oe, .port_pin_six_oe, .serial_input_pin(miso), .mod_out_pin_a, .mod_out_pin_a_oe,
      .mod_out_pin_b, .mod_out_pin_b_oe, .serial_input_oe, .rx_data, .ssi_busy, .count_value, .capture_value(),
      .capture_event, .compare_match(), .timer3_capture, .meas_running, .timer_output_clock());
   tmmu_periph peer (.clk, .rstn, .en(ssi_busy), .sclk(timer_mode == 4'h8 ? mod_out_pin_a : mod_out_pin_b),
      .mosi(timer_mode == 4'h8 ? mod_out_pin_b : mod_out_pin_a), .tx_byte(slave_byte), .miso, .rx_byte(slave_rx));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      ext_clk_a = 0;
      #3;
      forever #40 ext_clk_a = ~ext_clk_a;
   end
   initial begin
      #500000;
      err_total++;
      final_report();
   end
   always @(posedge clk) if (capture_event === 1'b1) ev_n++;
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // pins each mode takes from the port, table order
   function automatic logic own_a(input int m);
      return m inside {1, 3, 5, 7, 8, 9, 11};
   endfunction : own_a
   function automatic logic own_b(input int m);
      return m inside {2, 4, 6, 7, 8, 9, 10};
   endfunction : own_b
   // line level at slot s of a coded frame: manchester ~bit then bit; pwm code high, bit, low
   function automatic logic line_lvl(input int pwm, input logic [7:0] d, input int s);
      logic bt;
      bt = d[7 - s / (2 + pwm)];
      return pwm ? (s % 3 == 0 || (s % 3 == 1 && bt)) : (s % 2 == 1 ? bt : !bt);
   endfunction : line_lvl
   task automatic pulse(input logic alt);
      if (alt) capture_alt <= 1; else capture_pin <= 1;
      cyc(8);
      if (alt) capture_alt <= 0; else capture_pin <= 0;
      cyc(8);
   endtask : pulse
   task automatic final_report();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   initial begin
      seed = 32'h1366;
      rstn = 0;
      {timer_enable_bit, toggle_preset, ext_clk_b, tx_start, capture_source_select, capture_pin, capture_alt} = '0;
      {meas_start_bit, port_pin_five, port_pin_six, port_pin_seven_oe, port_pin_five_oe, port_pin_six_oe} = '0;
      {fixed_top_select, code_select, capture_edge_select, clock_select, timer_mode} = '0;
      {tx_data_reg, slave_byte, compare_value, shift_clock_idle_level} = '0;
      ssi_enable = 1;
      cyc(10);
      rstn <= 1;
      cyc(3);
      timer_enable_bit <= 1;
      for (int m = 0; m < 13; m++) begin
         timer_mode <= 4'(m);
         {port_pin_five, port_pin_six, port_pin_five_oe, port_pin_six_oe, port_pin_seven_oe} <= 5'($random(seed));
         code_select <= 2'($random(seed));
         cyc(4);
         `CHK(mod_out_pin_a_oe, own_a(m) | port_pin_five_oe, "pin a enable")
         `CHK(mod_out_pin_b_oe, own_b(m) | port_pin_six_oe, "pin b enable")
         `CHK(serial_input_oe, m != 9 && port_pin_seven_oe, "input pin enable")
         if (!own_a(m)) `CHK(mod_out_pin_a, port_pin_five, "pin a port value")
         if (!own_b(m)) `CHK(mod_out_pin_b, port_pin_six, "pin b port value")
      end
      timer_mode <= 4'h3;
      compare_value <= 10'h05A;
      for (int t = 0; t < 4; t++) begin
         fixed_top_select <= 2'(t);
         mx = '0;
         repeat (1100) @(posedge clk) if (count_value > mx) mx = count_value;
         `CHK(mx, tops[t], "fixed top")
      end
      timer_mode <= 4'h0;
      clock_select <= 3'h1;
      compare_value <= 10'h3FF;
      cyc(20);
      c0 = count_value;
      cyc(80);
      `CHK(10'(count_value - c0), 10'h00A, "link clock count")
      clock_select <= 3'h0;
      compare_value <= 10'h007;
      for (int k = 0; k < 2; k++) begin
         b = 8'($random(seed));
         timer_mode <= 4'(5 + k);
         code_select <= k ? tmmu_pkg::CODE_PWM : tmmu_pkg::CODE_MANCH;
         tx_data_reg <= b;
         // restart the counter: a count left above the new top would hold the first frame for a wrap
         timer_enable_bit <= 0;
         cyc(4);
         {timer_enable_bit, tx_start} <= 2'h3;
         @(posedge clk) tx_start <= 0;
         cyc(5);
         for (int s = 0; s < 8 * (2 + k); s++) begin
            `CHK(k ? mod_out_pin_b : mod_out_pin_a, line_lvl(k, b, s), "line code")
            cyc(8);
         end
      end
      for (int k = 0; k < 12; k++) begin
         b = k == 0 ? 8'h00 : k == 1 ? 8'hFF : 8'($random(seed));
         timer_mode <= 4'(7 + k % 3);
         shift_clock_idle_level <= k[2];
         tx_data_reg <= b;
         slave_byte <= 8'($random(seed));
         cyc(4);
         tx_start <= 1;
         @(posedge clk) tx_start <= 0;
         for (int w = 0; w < 400 && (w < 6 || ssi_busy !== 1'b0); w++) @(posedge clk);
         `CHK(slave_rx, b, "frame out")
         if (k % 3 == 2) `CHK(rx_data, slave_byte, "frame in")
      end
      timer_mode <= 4'hB;
      for (int c = 0; c < 8; c++) begin
         capture_edge_select <= 2'(c);
         capture_source_select <= c[2];
         cyc(8);
         ev_n = 0;
         for (int p = 0; p < 4; p++) pulse((p < 2) ^ c[2]);
         `CHK(ev_n, 2 * c[0] + 2 * c[1], "capture events")
      end
      timer_mode <= 4'hC;
      clock_select <= 3'h4;
      meas_start_bit <= 1;   // bench sensor edges are clean, so no second-timer filter is modelled
      for (int w = 0; w < 100 && meas_running !== 1'b1; w++) @(posedge clk);
      `CHK(meas_running, 1'b1, "sensor start")
      for (int w = 0; w < 200 && timer3_capture !== 1'b1; w++) @(posedge clk);
      `CHK(timer3_capture, 1'b1, "sensor compare capture")
      final_report();
   end
endmodule : tb
